/* File: logic/sar_adc_consts.vh */
// Functional notes
// - approximation resolves msb first; after lsb the whole word goes to result.
// - result reloaded at every conversion end, read as one 8-bit value.
// - result register value is undefined until the first conversion completes.
// - pins not assigned analog stay usable as digital port pins.
// - mode register resets to 01H; bit and byte writes accepted.
// - three-bit channel field selects one of eight inputs, ascending.
// - conversion-time code sets length in oscillator periods, halved with clock mode one.
// - bit 6 selects start source: zero software, one external trigger.
// - bit 7 stops conversion when zero, enables operation when one.
// - input-select register resets to 00H, written as a byte.
// - count n makes inputs 0..n-1 analog; values above 8 prohibited.
// - pull-up disabled on every analog pin regardless of option.
// - hardware start: one conversion per trigger, then idle awaiting next.
// - software start: conversions repeat back to back until mode rewritten.
// - mode rewrite with run set aborts and restarts per new setting.
// - mode write with run clear halts conversion at once.
`ifndef SAR_ADC_CONSTS_VH
`define SAR_ADC_CONSTS_VH
`define ADDR_MODE 16'hFF80
`define ADDR_PINCNT 16'hFF84
`define ADDR_RESULT 16'hFF88
`define ADDR_STATUS 16'hFF8C
`define MODE_RESET 8'h01
`define PINCNT_RESET 8'h00
`define BIT_RUN 7
`define BIT_TRIG 6
`define BIT_SPEED 0
`define PRESCALE_DIV 8'h13
`endif

/* File: logic/sar_step_timer.v */
`timescale 1ns/1ps
// one-cycle enable every ticks+1 pulses of the oscillator tick
module sar_step_timer (
  input wire core_clk,
  input wire arst_n,
  input wire run,
  input wire oscTick,
  input wire [7:0] ticks,
  output wire stepEn
);
  reg [7:0] cnt_q;
  assign stepEn = run && oscTick && (cnt_q == ticks);
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_q <= 8'h00;
    else if (!run)
      cnt_q <= 8'h00;
    else if (oscTick)
      cnt_q <= (cnt_q == ticks) ? 8'h00 : cnt_q + 8'h01;
  end
endmodule // sar_step_timer

/* File: logic/sar_adc_control.v */
`timescale 1ns/1ps
`include "sar_adc_consts.vh"
module sar_adc_control (
  input wire core_clk,
  input wire arst_n,
  input wire [15:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire clockModeSelect,
  input wire externalTriggerInput,
  input wire compareHigh,
  input wire [7:0] portPullupOption,
  output wire [2:0] channelSelect,
  output wire [7:0] tapCode,
  output wire sampleActive,
  output wire [7:0] analogPinMask,
  output wire [7:0] pullupEnable,
  output wire conversionDoneIrq
);
  // ****************************************
  // register bus
  // ****************************************
  localparam IDLE = 2'b00;
  localparam SAMPLE = 2'b01;
  localparam DECIDE = 2'b10;
  reg [7:0] mode_q;
  reg [3:0] pinCount_q;
  reg [7:0] result_q;
  reg [7:0] approx_q;
  reg [7:0] trial_q;
  reg [1:0] state_q;
  reg doneFlag_q;
  reg [7:0] pre_q;
  reg [31:0] rdata;
  wire access = psel && penable;
  wire wrMode = access && pwrite && paddr == `ADDR_MODE && pstrb[0];
  wire wrPin = access && pwrite && paddr == `ADDR_PINCNT && pstrb[0];
  wire wrStat = access && pwrite && paddr == `ADDR_STATUS && pstrb[0];
  wire known = paddr == `ADDR_MODE || paddr == `ADDR_PINCNT ||
    paddr == `ADDR_RESULT || paddr == `ADDR_STATUS;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !known;
  always @*
  begin
    rdata = 32'h00000000;
    case (paddr)
      `ADDR_MODE: rdata = {24'h000000, mode_q};
      `ADDR_PINCNT: rdata = {28'h0000000, pinCount_q};
      `ADDR_RESULT: rdata = {24'h000000, result_q};
      `ADDR_STATUS: rdata = {30'h00000000, state_q != IDLE, doneFlag_q};
      default: rdata = 32'h00000000;
    endcase
  end
  assign prdata = (psel && !pwrite) ? rdata : 32'h00000000;
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_q <= `MODE_RESET;
      pinCount_q <= 4'h0;
    end
    else
    begin
      if (wrMode)
        mode_q <= pwdata[7:0];
      if (wrPin)
        pinCount_q <= pwdata[3:0];
    end
  end
  // ****************************************
  // pins
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : pins
      assign analogPinMask[i] = pinCount_q > i;
      assign pullupEnable[i] = portPullupOption[i] && !analogPinMask[i];
    end
  endgenerate
  assign channelSelect = mode_q[3:1];
  // ****************************************
  // timing
  // ****************************************
  // oscillator rate approximated by a fixed prescale of the core clock
  wire oscTick = pre_q == `PRESCALE_DIV;
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      pre_q <= 8'h00;
    else
      pre_q <= oscTick ? 8'h00 : pre_q + 8'h01;
  end
  // conversion length split in ten equal steps: two sample, eight decisions
  reg [7:0] ticks;
  always @*
  begin
    case (mode_q[5:4])
      2'b00: ticks = 8'd8;
      2'b01: ticks = 8'd4;
      default: ticks = mode_q[0] ? 8'd10 : 8'd5;
    endcase
    if (!clockModeSelect)
      ticks = {ticks[6:0], 1'b0};
    ticks = ticks - 8'd1;
  end
  wire busy = state_q != IDLE;
  wire stepEn;
  sar_step_timer timer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .run(busy && !wrMode),
    .oscTick(oscTick),
    .ticks(ticks),
    .stepEn(stepEn)
  );
  // ****************************************
  // sequencer
  // ****************************************
  reg sampleStep_q;
  wire swStart = !mode_q[`BIT_TRIG] && mode_q[`BIT_RUN];
  wire hwStart = mode_q[`BIT_TRIG] && mode_q[`BIT_RUN] && externalTriggerInput;
  wire [7:0] decided = compareHigh ? approx_q : (approx_q & ~trial_q);
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= IDLE;
      approx_q <= 8'h00;
      trial_q <= 8'h00;
      sampleStep_q <= 1'b0;
      doneFlag_q <= 1'b0;
      result_q <= 8'h00; // value not guaranteed to software
    end
    else
    begin
      if (wrStat && pwdata[0])
        doneFlag_q <= 1'b0;
      if (wrMode)
        state_q <= IDLE; // abort, restart next cycle if swStart or hwStart is set
      else
      begin
        case (state_q)
          IDLE:
            if (swStart || hwStart)
            begin
              state_q <= SAMPLE;
              sampleStep_q <= 1'b0;
            end
          SAMPLE:
            if (!mode_q[`BIT_RUN])
              state_q <= IDLE;
            else if (stepEn)
            begin
              sampleStep_q <= 1'b1;
              if (sampleStep_q)
              begin
                state_q <= DECIDE;
                approx_q <= 8'h80;
                trial_q <= 8'h80;
              end
            end
          DECIDE:
            if (!mode_q[`BIT_RUN])
              state_q <= IDLE;
            else if (stepEn)
            begin
              if (trial_q == 8'h01)
              begin
                result_q <= decided;
                doneFlag_q <= 1'b1;
                state_q <= swStart ? SAMPLE : IDLE;
                sampleStep_q <= 1'b0;
              end
              else
              begin
                approx_q <= decided | (trial_q >> 1);
                trial_q <= trial_q >> 1;
              end
            end
          default: state_q <= IDLE;
        endcase
      end
    end
  end
  assign tapCode = approx_q;
  assign sampleActive = state_q == SAMPLE;
  assign conversionDoneIrq = doneFlag_q;
endmodule // sar_adc_control

/* File: dv/sar_adc_control_asserts.sv */
`timescale 1ns/1ps
`include "sar_adc_consts.vh"
module sar_adc_control_asserts (
  input wire core_clk,
  input wire arst_n,
  input wire [15:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire pslverr,
  input wire [7:0] portPullupOption,
  input wire [2:0] channelSelect,
  input wire sampleActive,
  input wire [7:0] analogPinMask,
  input wire [7:0] pullupEnable
);
  wire modeWr = psel && penable && pwrite && paddr == `ADDR_MODE;
  reg runQ;
  // run bit shadow, so no view of the register file is needed
  always @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      runQ <= 1'b0;
    else if (modeWr)
      runQ <= pwdata[7];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  property p_chan; modeWr |=> channelSelect == $past(pwdata[3:1]); endproperty
  a_chan: assert property (p_chan) else $error("channel select mismatch");
  property p_halt; modeWr && !pwdata[7] |=> !sampleActive; endproperty
  a_halt: assert property (p_halt) else $error("halt not immediate");
  property p_restart; modeWr && pwdata[7:6] == 2'b10 |-> ##[1:3] sampleActive; endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_hwWait; modeWr && pwdata[7:6] == 2'b11 |=> !sampleActive; endproperty
  a_hwWait: assert property (p_hwWait) else $error("no trigger wait");
  property p_stop; !runQ |-> !sampleActive; endproperty
  a_stop: assert property (p_stop) else $error("active while stopped");
  property p_thermo; (analogPinMask & (analogPinMask + 8'h01)) == 8'h00; endproperty
  a_thermo: assert property (p_thermo) else $error("mask not contiguous");
  property p_pull;
    pullupEnable == (portPullupOption & ~analogPinMask);
  endproperty
  a_pull: assert property (p_pull) else $error("pullup on analog pin");
  property p_err;
    psel && penable |-> pslverr ==
      !(paddr inside {`ADDR_MODE, `ADDR_PINCNT, `ADDR_RESULT, `ADDR_STATUS});
  endproperty
  a_err: assert property (p_err) else $error("slave error wrong");
endmodule // sar_adc_control_asserts
bind sar_adc_control sar_adc_control_asserts chk_u (.core_clk(core_clk), .arst_n(arst_n),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .pslverr(pslverr), .portPullupOption(portPullupOption), .channelSelect(channelSelect),
  .sampleActive(sampleActive), .analogPinMask(analogPinMask), .pullupEnable(pullupEnable));

/* File: dv/analog_source.sv */
`timescale 1ns/1ps
module analog_source (
  input wire [63:0] levels,
  input wire [2:0] channelSelect,
  input wire [7:0] tapCode,
  output wire compareHigh
);
  // ideal comparator: any converter error shows as a result mismatch
  assign compareHigh = levels[channelSelect * 8 +: 8] >= tapCode;
endmodule // analog_source

/* File: dv/sar_adc_control_tb.sv */
`timescale 1ns/1ps
`include "sar_adc_consts.vh"
module sar_adc_control_tb;
  reg core_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, clock_mode_select = 1, trigger_source_bit = 0, err;
  reg [15:0] paddr = 0;
  reg [31:0] pwdata = 0, seed = 32'h1255, rd;
  reg [7:0] portPullupOption = 0;
  reg [63:0] levels = 0;
  wire [31:0] prdata;
  wire pready, pslverr, cmpHi, sampleActive, doneIrq;
  wire [2:0] channelSelect;
  wire [7:0] tapCode, analogPinMask, pullupEnable;
  int failures = 0, samplesChecked = 0, k, t, v, tbl[4] = '{80, 40, 50, 100};
  bit [2:0] codes[4] = '{3'b001, 3'b011, 3'b100, 3'b101};
  always #5 core_clk = ~core_clk;
  sar_adc_control dut_u (.core_clk(core_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clockModeSelect(clock_mode_select), .externalTriggerInput(trigger_source_bit),
    .compareHigh(cmpHi), .portPullupOption(portPullupOption), .channelSelect(channelSelect),
    .tapCode(tapCode), .sampleActive(sampleActive), .analogPinMask(analogPinMask),
    .pullupEnable(pullupEnable), .conversionDoneIrq(doneIrq));
  analog_source src_u (.levels(levels), .channelSelect(channelSelect), .tapCode(tapCode),
    .compareHigh(cmpHi));
  // ****
  // model and bus tasks
  // ****
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int sarRef(int lvl);
    int r = 0;
    for (int b = 7; b >= 0; b--) if (lvl >= (r | (1 << b))) r = r | (1 << b);
    return r;
  endfunction
  task automatic chk(input string n, input [31:0] e, input [31:0] s);
    samplesChecked++;
    if (s !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      failures++;
    end
  endtask
  task automatic apb(input [15:0] a, input w, input [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic waitDone();
    for (t = 0; t < 5000 && doneIrq !== 1'b1; t++) @(posedge core_clk);
    // a conversion that never completes must not pass silently
    if (t >= 5000)
    begin
      $display("[ERR] doneWait expected 1 seen 0");
      failures++;
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (80000) @(posedge core_clk);
    failures++;
    final_report;
  end
  initial
  begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    apb(`ADDR_MODE, 0, 0); chk("mode", 8'h01, rd);
    apb(`ADDR_PINCNT, 0, 0); chk("count", 0, rd);
    apb(16'hFF90, 0, 0); chk("slverr", 1, err);
    for (k = 0; k <= 8; k++)
    begin
      portPullupOption <= 8'(xs());
      apb(`ADDR_PINCNT, 1, k); apb(`ADDR_PINCNT, 0, 0); chk("count", k, rd);
      chk("mask", (1 << k) - 1, analogPinMask);
      chk("pullup", portPullupOption & ~((1 << k) - 1), pullupEnable);
    end
    for (k = 0; k < 8; k++)
    begin
      levels <= {xs(), xs()};
      clock_mode_select <= k > 3 && codes[k % 4][1:0] == 2'b01;
      apb(`ADDR_MODE, 1, 8'h01); apb(`ADDR_STATUS, 1, 1);
      apb(`ADDR_MODE, 1, {2'b10, codes[k % 4][2:1], k[2:0], codes[k % 4][0]});
      waitDone(); v = tbl[k % 4] * (clock_mode_select ? 20 : 40);
      chk("convTime", 1, t >= v - 40 && t <= v + 40);
      chk("chan", k, channelSelect);
      apb(`ADDR_RESULT, 0, 0); chk("result", sarRef(levels[k * 8 +: 8]), rd);
      apb(`ADDR_STATUS, 1, 1); waitDone(); chk("again", 1, doneIrq);
    end
    apb(`ADDR_MODE, 1, 8'h01); apb(`ADDR_STATUS, 1, 1); apb(`ADDR_MODE, 1, 8'hC3);
    repeat (2000) @(posedge core_clk); chk("hwIdle", 0, doneIrq);
    for (k = 0; k < 2; k++)
    begin
      @(posedge core_clk) trigger_source_bit <= 1'b1;
      @(posedge core_clk) trigger_source_bit <= 1'b0;
      repeat (k * 500) @(posedge core_clk);
      if (k == 1) apb(`ADDR_MODE, 1, 8'h01);
      if (k == 0) waitDone();
      apb(`ADDR_RESULT, 0, 0);
      if (k == 0) chk("hwRes", sarRef(levels[15:8]), rd);
      apb(`ADDR_STATUS, 1, 1); repeat (2000) @(posedge core_clk); chk("once", 0, doneIrq);
    end
    apb(`ADDR_MODE, 1, 8'h01); apb(`ADDR_MODE, 0, 0); chk("stopped", 8'h01, rd);
    final_report;
  end
endmodule // sar_adc_control_tb
